/* pkg/scrl_pkg.sv */
// shared constants and types for the status/control byte slave
package scrl_pkg;
  // register map, offset relative to the jumpered 1K base
  localparam logic [15:0] STATUS_OFFSET = 16'h0081;
  localparam int BASE_LSB = 10;
  // field positions inside the status/control byte
  localparam int BIT_RED = 0;
  localparam int BIT_GREEN = 1;
  localparam int BIT_PEND = 2;
  localparam int BIT_ENABLE = 3;
  // red lit, green dark, interrupts off and nothing pending
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // short i/o address modifiers accepted
  localparam logic [5:0] AM_SHORT_USER = 6'h29;
  localparam logic [5:0] AM_SHORT_SUPER = 6'h2d;
  // defaults for the interrupter, arbitrary values
  localparam logic [2:0] IRQ_LEVEL_DEFAULT = 3'h1;
  localparam logic [7:0] IRQ_VECTOR_DEFAULT = 8'h40;

  // backplane inputs travel together through the synchroniser
  typedef struct packed {
    logic as_n;
    logic ds1_n;
    logic ds0_n;
    logic write_n;
    logic iack_n;
    logic iackin_n;
    logic [5:0] am;
    logic [15:1] addr;
    logic [15:0] data;
    logic [5:0] base_sw;
  } scrl_bus_t;

  typedef enum logic [2:0] {ST_IDLE, ST_DRIVE, ST_ACK, ST_PASS} scrl_state_t;
endpackage

/* rtl/scrl_regbank.sv */
// status/control byte of a 16-bit short i/o slave, with led, interrupt and ack chain
`timescale 1ns/10ps
module scrl_regbank #(
  parameter logic [2:0] IRQ_LEVEL = scrl_pkg::IRQ_LEVEL_DEFAULT,
  parameter logic [7:0] IRQ_VECTOR = scrl_pkg::IRQ_VECTOR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire scrl_pkg::scrl_bus_t bus_in,
  input wire logic module_event,
  output logic [15:0] data_o,
  output logic data_oe_n,
  output logic dtack_o,
  output logic dtack_oe_n,
  output logic irq_o,
  output logic irq_oe_n,
  output logic iackout_n,
  output logic red_led_on,
  output logic green_led_on
);
  scrl_pkg::scrl_bus_t bus_s;
  scrl_pkg::scrl_state_t state;
  scrl_pkg::scrl_state_t next_state;
  logic red_off;
  logic green_on;
  logic int_en;
  logic int_pend;
  logic vec_cyc;
  logic next_red_off;
  logic next_green_on;
  logic next_int_en;
  logic next_int_pend;
  logic next_vec_cyc;
  logic [15:0] next_data_o;
  logic next_data_oe_n;
  logic next_dtack_oe_n;
  logic next_iackout_n;
  logic strobe;
  logic store_cyc;
  logic ack_clear;

  // all backplane inputs arrive asynchronously
  scrl_sync3 #(
    .W($bits(scrl_pkg::scrl_bus_t))
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d(bus_in),
    .q(bus_s)
  );

  // address decode for the status byte, any lane that covers offset 81h
  function automatic logic hit_status(input scrl_pkg::scrl_bus_t b);
    logic am_ok;
    am_ok = (b.am == scrl_pkg::AM_SHORT_USER) || (b.am == scrl_pkg::AM_SHORT_SUPER);
    hit_status = am_ok && b.iack_n
      && (b.addr[15:scrl_pkg::BASE_LSB] == b.base_sw)
      && (b.addr[scrl_pkg::BASE_LSB-1:1] == scrl_pkg::STATUS_OFFSET[scrl_pkg::BASE_LSB-1:1])
      && !b.ds0_n;
  endfunction

  assign strobe = !bus_s.as_n && (!bus_s.ds0_n || !bus_s.ds1_n);
  assign store_cyc = (state == scrl_pkg::ST_DRIVE) && !vec_cyc && !bus_s.write_n && !bus_s.ds0_n;
  assign ack_clear = (state == scrl_pkg::ST_DRIVE) && vec_cyc;

  // bus cycle sequencing and register updates
  always_comb
  begin
    next_state = state;
    next_red_off = red_off;
    next_green_on = green_on;
    next_int_en = int_en;
    next_vec_cyc = vec_cyc;
    next_data_o = data_o;
    next_data_oe_n = data_oe_n;
    next_dtack_oe_n = dtack_oe_n;
    next_iackout_n = iackout_n;
    // a new event beats a clear in the same cycle
    next_int_pend = (int_pend && !ack_clear) || module_event;
    unique case (state)
      scrl_pkg::ST_IDLE:
      begin
        if (strobe && !bus_s.iack_n && !bus_s.iackin_n)
        begin
          if (!irq_oe_n && bus_s.addr[3:1] == IRQ_LEVEL)
          begin
            next_vec_cyc = 1'b1;
            next_data_o = {8'h00, IRQ_VECTOR};
            next_data_oe_n = 1'b0;
            next_state = scrl_pkg::ST_DRIVE;
          end
          else
          begin
            next_iackout_n = 1'b0;
            next_state = scrl_pkg::ST_PASS;
          end
        end
        else if (strobe && bus_s.iack_n && hit_status(bus_s))
        begin
          next_vec_cyc = 1'b0;
          if (bus_s.write_n)
          begin
            // upper lane reads zero, bits 4-7 read zero as well
            next_data_o = {8'h00, 4'h0, int_en, int_pend, green_on, red_off};
            next_data_oe_n = 1'b0;
          end
          next_state = scrl_pkg::ST_DRIVE;
        end
      end
      scrl_pkg::ST_DRIVE:
      begin
        if (store_cyc)
        begin
          next_red_off = bus_s.data[scrl_pkg::BIT_RED];
          next_green_on = bus_s.data[scrl_pkg::BIT_GREEN];
          next_int_en = bus_s.data[scrl_pkg::BIT_ENABLE];
        end
        // data has stood one cycle before acknowledge falls
        next_dtack_oe_n = 1'b0;
        next_state = scrl_pkg::ST_ACK;
      end
      scrl_pkg::ST_ACK:
      begin
        if (bus_s.ds0_n && bus_s.ds1_n)
        begin
          next_dtack_oe_n = 1'b1;
          next_data_oe_n = 1'b1;
          next_vec_cyc = 1'b0;
          next_state = scrl_pkg::ST_IDLE;
        end
      end
      scrl_pkg::ST_PASS:
      begin
        // hold the chain low until the master ends the ack cycle
        if (bus_s.as_n || bus_s.iackin_n)
        begin
          next_iackout_n = 1'b1;
          next_state = scrl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // registers; outputs all come straight from here
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= scrl_pkg::ST_IDLE;
      red_off <= scrl_pkg::STATUS_RESET[scrl_pkg::BIT_RED];
      green_on <= scrl_pkg::STATUS_RESET[scrl_pkg::BIT_GREEN];
      int_en <= scrl_pkg::STATUS_RESET[scrl_pkg::BIT_ENABLE];
      int_pend <= scrl_pkg::STATUS_RESET[scrl_pkg::BIT_PEND];
      vec_cyc <= 1'b0;
      data_o <= 16'h0000;
      data_oe_n <= 1'b1;
      dtack_o <= 1'b0;
      dtack_oe_n <= 1'b1;
      irq_o <= 1'b0;
      irq_oe_n <= 1'b1;
      iackout_n <= 1'b1;
      red_led_on <= !scrl_pkg::STATUS_RESET[scrl_pkg::BIT_RED];
      green_led_on <= scrl_pkg::STATUS_RESET[scrl_pkg::BIT_GREEN];
    end
    else
    begin
      state <= next_state;
      red_off <= next_red_off;
      green_on <= next_green_on;
      int_en <= next_int_en;
      int_pend <= next_int_pend;
      vec_cyc <= next_vec_cyc;
      data_o <= next_data_o;
      data_oe_n <= next_data_oe_n;
      dtack_o <= 1'b0;
      dtack_oe_n <= next_dtack_oe_n;
      irq_o <= 1'b0;
      // open-drain request, released as soon as the ack clears pending
      irq_oe_n <= !(next_int_pend && next_int_en);
      iackout_n <= next_iackout_n;
      red_led_on <= !next_red_off;
      green_led_on <= next_green_on;
    end
  end

  // checks on the slave behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_IRQ_NEEDS_ENABLE:
    assert property (!irq_oe_n |-> int_en && int_pend)
    else $error("interrupt request driven while disabled");
  AST_SET_WINS:
    assert property (module_event |=> int_pend)
    else $error("interrupt event lost");
  AST_PEND_READ_ONLY:
    assert property (store_cyc && !module_event |=> int_pend == $past(int_pend))
    else $error("write changed pending bit");
  AST_ENABLE_STORE:
    assert property (store_cyc |=> int_en == $past(bus_s.data[3]))
    else $error("enable bit not stored");
  AST_RED_LED:
    assert property (store_cyc |=> red_led_on == !$past(bus_s.data[0]))
    else $error("red led does not follow write");
  AST_GREEN_LED:
    assert property (store_cyc |=> green_led_on == $past(bus_s.data[1]))
    else $error("green led does not follow write");
  AST_DATA_BEFORE_DTACK:
    assert property ($fell(dtack_oe_n) && !data_oe_n |-> $past(!data_oe_n))
    else $error("acknowledge before read data valid");
  AST_READ_VALUE:
    assert property (!dtack_oe_n && !data_oe_n && !vec_cyc |-> data_o[3] == int_en && data_o[15:8] == 8'h00)
    else $error("status read data wrong");
  AST_DTACK_RELEASE:
    assert property (state == scrl_pkg::ST_ACK && bus_s.ds0_n && bus_s.ds1_n |=> dtack_oe_n && data_oe_n)
    else $error("acknowledge not released");
  AST_IACKOUT_PASS:
    assert property ($fell(iackout_n) |-> $past(!bus_s.iackin_n) && $past(!bus_s.iack_n)
      && ($past(irq_oe_n) || $past(bus_s.addr[3:1]) != IRQ_LEVEL))
    else $error("chain passed without ack cycle");

  COV_READ: cover property (state == scrl_pkg::ST_DRIVE && !vec_cyc && bus_s.write_n);
  COV_WRITE: cover property (store_cyc);
  COV_VECTOR: cover property (ack_clear);
  COV_PASS: cover property ($fell(iackout_n));
endmodule

/* rtl/scrl_sync3.sv */
// three-stage synchroniser with agreement filter for backplane inputs
`timescale 1ns/10ps
module scrl_sync3 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // a bit moves only when stages two and three agree
  always_comb
  begin
    next_q = q;
    for (int i = 0; i < W; i++)
    begin
      if (s2[i] == s3[i])
        next_q[i] = s3[i];
    end
  end

  // s1 is read by s2 only; reset parks lines at their idle high level
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      q <= '1;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

/* tb/scrl_master.sv */
// backplane bus master model driving the status/control slave
`timescale 1ns/10ps
module scrl_master (
  input wire logic clk,
  input wire logic [5:0] base,
  input wire logic [15:0] data_o,
  input wire logic dtack_oe_n,
  input wire logic iackout_n,
  output scrl_pkg::scrl_bus_t bus_in
);
  // idle bus: all strobes high
  initial bus_in = '1;
  // one cycle; request held until dtack, chain pass or 16 clocks, then dropped together
  task automatic cyc(input logic wr, input logic ak, input logic [5:0] am, input logic [15:1] a,
    input logic [1:0] ds, input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] got);
    int n;
    got = 2'h0;
    rd = 16'h0;
    @(posedge clk);
    bus_in.am <= am;
    bus_in.addr <= a;
    bus_in.base_sw <= base;
    bus_in.write_n <= ~wr;
    bus_in.iack_n <= ~ak;
    bus_in.iackin_n <= ~ak;
    bus_in.data <= wr ? wd : ~bus_in.data;
    bus_in.as_n <= 1'b0;
    {bus_in.ds1_n, bus_in.ds0_n} <= ds;
    for (n = 0; n < 16 && got == 2'h0; n++)
    begin
      @(posedge clk);
      got = {iackout_n === 1'b0, dtack_oe_n === 1'b0};
      rd = data_o;
    end
    // released lines show garbage, never the old value
    bus_in.as_n <= 1'b1;
    {bus_in.ds1_n, bus_in.ds0_n} <= 2'h3;
    bus_in.iack_n <= 1'b1;
    bus_in.iackin_n <= 1'b1;
    bus_in.addr <= ~a;
    bus_in.data <= ~bus_in.data;
    // strobes stay high long enough for the slave's input filter to see the gap
    for (n = 0; n < 16 && (n < 5 || !(dtack_oe_n === 1'b1 && iackout_n === 1'b1)); n++)
      @(posedge clk);
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the status/control byte slave
`timescale 1ns/10ps
module testbench;
  logic clk, reset, module_event;
  logic [5:0] base;
  scrl_pkg::scrl_bus_t bus_in;
  logic [15:0] data_o, rd;
  logic data_oe_n, dtack_o, dtack_oe_n, irq_o, irq_oe_n, iackout_n, red_led_on, green_led_on;
  logic [1:0] got;
  logic [31:0] seed = 32'h21;
  logic [7:0] v;
  int miscompares = 0;
  int checked = 0;
  int i;
  scrl_regbank scrl_regbank_i (.clk(clk), .reset(reset), .bus_in(bus_in), .module_event(module_event),
    .data_o(data_o), .data_oe_n(data_oe_n), .dtack_o(dtack_o), .dtack_oe_n(dtack_oe_n), .irq_o(irq_o),
    .irq_oe_n(irq_oe_n), .iackout_n(iackout_n), .red_led_on(red_led_on), .green_led_on(green_led_on));
  scrl_master scrl_master_i (.clk(clk), .base(base), .data_o(data_o), .dtack_oe_n(dtack_oe_n),
    .iackout_n(iackout_n), .bus_in(bus_in));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // expected byte: upper nibble reads zero, pending from the bench model
  function automatic logic [15:0] st(input logic [7:0] b, input logic p);
    return {12'h0, b[3], p, b[1:0]};
  endfunction
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] b);
    scrl_master_i.cyc(1'b1, 1'b0, scrl_pkg::AM_SHORT_SUPER, {base, 9'h040}, 2'h2, {8'h0, b}, rd, got);
    check("wack", {14'h0, got}, 16'h1);
  endtask
  task automatic rdx(input logic [15:0] e, input logic [5:0] am);
    scrl_master_i.cyc(1'b0, 1'b0, am, {base, 9'h040}, 2'h2, 16'h0, rd, got);
    check("rack", {14'h0, got}, 16'h1);
    check("rdat", rd, e);
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial
  begin
    #400000;
    miscompares++;
    summarize();
  end
  // main sequence
  initial
  begin
    reset = 1'b1;
    module_event = 1'b0;
    base = 6'h05;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("rstled", {14'h0, red_led_on, green_led_on}, 16'h2);
    rdx(16'h0, scrl_pkg::AM_SHORT_USER);
    $display("test reset done");
    // random bytes with both corners first; base moves too
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      v = i == 0 ? 8'hff : i == 1 ? 8'h00 : seed[7:0];
      base <= seed[13:8];
      // let the new base settle before the task samples it for the address
      @(posedge clk);
      wr(v);
      check("led", {14'h0, red_led_on, green_led_on}, {14'h0, ~v[0], v[1]});
      rdx(st(v, 1'b0), i[0] ? scrl_pkg::AM_SHORT_USER : scrl_pkg::AM_SHORT_SUPER);
    end
    $display("test rw done");
    // wrong offset, wrong modifier, wrong base, high lane only
    for (i = 0; i < 4; i++)
    begin
      scrl_master_i.cyc(1'b0, 1'b0, i == 1 ? 6'h39 : 6'h29, {i == 2 ? ~base : base, i == 0 ? 9'h041 : 9'h040},
        i == 3 ? 2'h1 : 2'h2, 16'h0, rd, got);
      check("refuse", {14'h0, got}, 16'h0);
    end
    $display("test refuse done");
    wr(8'h00);
    @(posedge clk);
    module_event <= 1'b1;
    @(posedge clk);
    module_event <= 1'b0;
    repeat (3) @(posedge clk);
    check("irqoff", {15'h0, irq_oe_n}, 16'h1);
    rdx(st(8'h00, 1'b1), scrl_pkg::AM_SHORT_USER);
    wr(8'h08);
    check("irqon", {15'h0, irq_oe_n}, 16'h0);
    rdx(st(8'h08, 1'b1), scrl_pkg::AM_SHORT_USER);
    scrl_master_i.cyc(1'b0, 1'b1, 6'h29, {12'h0, scrl_pkg::IRQ_LEVEL_DEFAULT + 3'h1}, 2'h2, 16'h0, rd, got);
    check("pass", {14'h0, got}, 16'h2);
    scrl_master_i.cyc(1'b0, 1'b1, 6'h29, {12'h0, scrl_pkg::IRQ_LEVEL_DEFAULT}, 2'h2, 16'h0, rd, got);
    check("vack", {14'h0, got}, 16'h1);
    check("vec", {8'h0, rd[7:0]}, {8'h0, scrl_pkg::IRQ_VECTOR_DEFAULT});
    check("irqclr", {15'h0, irq_oe_n}, 16'h1);
    rdx(st(8'h08, 1'b0), scrl_pkg::AM_SHORT_USER);
    // word access: upper lane reads zero, low lane carries the byte
    scrl_master_i.cyc(1'b0, 1'b0, scrl_pkg::AM_SHORT_SUPER, {base, 9'h040}, 2'h0, 16'h0, rd, got);
    check("wack16", {14'h0, got}, 16'h1);
    check("word", rd, st(8'h08, 1'b0));
    check("idle", {13'h0, dtack_o, irq_o, data_oe_n}, 16'h1);
    $display("test irq done");
    summarize();
  end
endmodule
